// file: hw/fas_flash_device.sv
// Flash device end: array, command decode, algorithm timing and status word.
//
// Operation
// [RULE1] Ready flag low while algorithm runs.
// [RULE2] Busy reads anywhere return the status word.
// [RULE3] Host reads flags by half-word or byte.
// [RULE4] Read-only mode never returns the status word.
// [RULE5] Host discards first status after commands.
// [RULE6] Status bits 7,6,5,3,2; others undefined.
// [RULE7] Program polling returns inverted last data bit7.
// [RULE8] Erase polling reads 0, then 1.
// [RULE9] Toggle bit alternates while program or erase.
// [RULE10] Time-limit bit set when budget exceeded.
// [RULE11] Programming 1 over 0 locks the algorithm.
// [RULE12] Host aborts with read/reset on time limit.
// [RULE13] Sector erase starts after 35 us window.
// [RULE14] Erase timer 0 in window, accepts more sectors.
// [RULE15] Running erase ignores all but suspend.
// [RULE16] Second toggle alternates during any erase.
// [RULE17] Suspended erasing sectors give fixed suspend flags.
// [RULE18] Suspended, other sectors read array data.
// [RULE19] Suspended program reports its own flag pattern.
// [RULE20] Read/reset is default state after power-up, completion.
// [RULE21] Host polls completion before trusting array data.
// [RULE22] Suspend accepted only in sector erase phases.
// [RULE23] Access size 01 enables programming; reset read-only.
// [RULE24] Undefined bits zero; toggles flip per status read.
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module fas_flash_device #(
    parameter int DEPTH = 64,
    parameter int SECT_WORDS = 16,
    parameter int PROG_CYC = 20,
    parameter int ERASE_CYC = 200,
    parameter int LIMIT_CYC = 1000
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    fas_if.device bus,
    output logic flash_ready_flag_o,
    output logic time_limit_flag_o
);
    import fas_pkg::*;

    localparam int IDX_W = $clog2(DEPTH);
    localparam int NSECT = DEPTH / SECT_WORDS;
    localparam int SB = $clog2(NSECT);

    logic [1:0] access_size_field_q;
    fas_state_t state_q, state_d;
    logic [2:0] step_q, step_d;
    logic [15:0] mem_q [DEPTH];
    logic [15:0] last_program_data_q;
    logic [IDX_W-1:0] pa_q;
    logic lock_q;
    logic [NSECT-1:0] sect_mask_q;
    logic [15:0] pcnt_q, ecnt_q, tmo_q;
    logic time_limit_flag_q;
    logic alternating_busy_flag_q, suspend_alternating_flag_q;
    logic [15:0] rdata_q;
    logic ready_q;

    logic prog_mode, wr_ok, busy, busy_d, in_erase_sect, flag_read, unl1, unl2;
    logic go_prog, go_se, go_ce, add_sect, resume, suspend, abort;
    logic tmo_done, done_prog, done_erase;
    logic [IDX_W-1:0] idx;
    logic [SB-1:0] sect;
    logic [7:0] d8;
    logic [15:0] status;

    // Access size selects read-only or programming mode.
    // [RULE23] mode from field
    assign prog_mode = access_size_field_q == SZ_HALF;
    assign wr_ok = bus.wr && prog_mode;
    assign idx = bus.addr[IDX_W:1];
    assign sect = idx[IDX_W-1 -: SB];
    assign d8 = bus.wdata[7:0];
    assign unl1 = bus.addr == ADDR_UNLOCK1 && d8 == CMD_UNLOCK1;
    assign unl2 = bus.addr == ADDR_UNLOCK2 && d8 == CMD_UNLOCK2;
    assign in_erase_sect = sect_mask_q[sect];
    assign busy = state_q inside {FAS_PROG, FAS_SE_WAIT, FAS_SE_RUN, FAS_CE_RUN, FAS_SUSP_PROG};
    assign busy_d = state_d inside {FAS_PROG, FAS_SE_WAIT, FAS_SE_RUN, FAS_CE_RUN, FAS_SUSP_PROG};
    assign tmo_done = state_q == FAS_SE_WAIT && tmo_q == 16'(SE_TIMEOUT_CYC - 1);
    // [RULE11] locked program never ends
    assign done_prog = (state_q == FAS_PROG || state_q == FAS_SUSP_PROG) && !lock_q
                       && pcnt_q == 16'(PROG_CYC - 1);
    assign done_erase = (state_q == FAS_SE_RUN || state_q == FAS_CE_RUN) && ecnt_q == 16'(ERASE_CYC - 1);

    // Flags need programming mode and a non-word read, so software in read-only mode always gets the array.
    // [RULE2] status replaces array
    // [RULE4] no flags when read-only
    // [RULE18] non-erasing sectors read array
    assign flag_read = bus.rd && prog_mode && bus.size != SZ_WORD
                       && (busy || (state_q == FAS_SE_SUSP && in_erase_sect));

    // [RULE6] status word layout
    always_comb begin
        status = STATUS_RESET;
        case (state_q)
            FAS_PROG, FAS_SUSP_PROG: begin
                // [RULE7] inverted program data
                status[BIT_POLL] = ~last_program_data_q[7];
                status[BIT_ALT] = alternating_busy_flag_q;
                status[BIT_TLIM] = time_limit_flag_q;
                // [RULE19] suspended program pattern
                status[BIT_ETMR] = state_q == FAS_SUSP_PROG;
            end
            FAS_SE_WAIT: begin
                // [RULE14] timer window reads 0
                status[BIT_ALT] = alternating_busy_flag_q;
                status[BIT_TLIM] = time_limit_flag_q;
                status[BIT_ALT2] = suspend_alternating_flag_q;
            end
            FAS_SE_RUN, FAS_CE_RUN: begin
                // [RULE8] erase polls as 0
                // [RULE16] second toggle in erase
                status[BIT_ALT] = alternating_busy_flag_q;
                status[BIT_TLIM] = time_limit_flag_q;
                status[BIT_ETMR] = 1'b1;
                status[BIT_ALT2] = suspend_alternating_flag_q;
            end
            FAS_SE_SUSP: begin
                // [RULE17] suspended erasing sector
                status[BIT_ETMR] = 1'b1;
                status[BIT_ALT2] = suspend_alternating_flag_q;
            end
            default: status = STATUS_RESET;
        endcase
    end

    always_comb begin
        step_d = (state_q == FAS_IDLE || state_q == FAS_SE_SUSP) ? step_q : 3'h0;
        go_prog = 1'b0;
        go_se = 1'b0;
        go_ce = 1'b0;
        add_sect = 1'b0;
        resume = 1'b0;
        suspend = 1'b0;
        abort = 1'b0;
        if (wr_ok) begin
            case (state_q)
                FAS_IDLE, FAS_SE_SUSP: begin
                    // Any unexpected write, the reset code included, drops the sequence.
                    step_d = 3'h0;
                    case (step_q)
                        3'h0: begin
                            if (unl1) begin
                                step_d = 3'h1;
                            end else if (state_q == FAS_SE_SUSP && d8 == CMD_SECTOR) begin
                                resume = 1'b1;
                            end
                        end
                        3'h1: step_d = unl2 ? 3'h2 : 3'h0;
                        3'h2: begin
                            if (bus.addr == ADDR_UNLOCK1 && d8 == CMD_PROG) begin
                                step_d = 3'h6;
                            end else if (bus.addr == ADDR_UNLOCK1 && d8 == CMD_ERASE && state_q == FAS_IDLE) begin
                                step_d = 3'h3;
                            end
                        end
                        3'h3: step_d = unl1 ? 3'h4 : 3'h0;
                        3'h4: step_d = unl2 ? 3'h5 : 3'h0;
                        3'h5: begin
                            go_ce = bus.addr == ADDR_UNLOCK1 && d8 == CMD_CHIP;
                            go_se = d8 == CMD_SECTOR;
                        end
                        default: go_prog = state_q == FAS_IDLE || !in_erase_sect;
                    endcase
                end
                FAS_SE_WAIT: begin
                    // [RULE22] suspend in timeout window
                    if (d8 == CMD_SUSPEND) begin
                        suspend = 1'b1;
                    end else if (d8 == CMD_SECTOR) begin
                        // [RULE14] extra sectors accepted
                        add_sect = 1'b1;
                    end
                end
                // [RULE15] only suspend while erasing
                FAS_SE_RUN: suspend = d8 == CMD_SUSPEND;
                default: abort = d8 == CMD_RESET && time_limit_flag_q;
            endcase
        end
    end

    // [RULE20] read/reset is home state
    always_comb begin
        state_d = state_q;
        if (go_prog) begin
            state_d = state_q == FAS_IDLE ? FAS_PROG : FAS_SUSP_PROG;
        end else if (go_se) begin
            state_d = FAS_SE_WAIT;
        end else if (go_ce) begin
            state_d = FAS_CE_RUN;
        end else if (resume || tmo_done) begin
            state_d = FAS_SE_RUN;
        end else if (suspend) begin
            state_d = FAS_SE_SUSP;
        end else if (abort || done_erase) begin
            state_d = FAS_IDLE;
        end else if (done_prog) begin
            state_d = state_q == FAS_PROG ? FAS_IDLE : FAS_SE_SUSP;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= FAS_IDLE;
            step_q <= 3'h0;
        end else begin
            state_q <= state_d;
            step_q <= step_d;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            access_size_field_q <= ASZ_RESET;
        end else if (bus.asz_wr) begin
            access_size_field_q <= bus.asz;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            last_program_data_q <= 16'h0000;
            pa_q <= '0;
            lock_q <= 1'b0;
        end else if (go_prog) begin
            last_program_data_q <= bus.wdata;
            pa_q <= idx;
            lock_q <= |(bus.wdata & ~mem_q[idx]);
        end
    end

    // [RULE13] timeout before erase
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tmo_q <= 16'h0000;
            pcnt_q <= 16'h0000;
            ecnt_q <= 16'h0000;
        end else begin
            tmo_q <= go_se ? 16'h0000 : (state_q == FAS_SE_WAIT ? tmo_q + 16'h0001 : tmo_q);
            if (go_prog) begin
                pcnt_q <= 16'h0000;
            end else if ((state_q == FAS_PROG || state_q == FAS_SUSP_PROG) && pcnt_q != 16'hFFFF) begin
                pcnt_q <= pcnt_q + 16'h0001;
            end
            // Erase progress is kept across a suspension.
            if (go_se || go_ce) begin
                ecnt_q <= 16'h0000;
            end else if ((state_q == FAS_SE_RUN || state_q == FAS_CE_RUN) && ecnt_q != 16'hFFFF) begin
                ecnt_q <= ecnt_q + 16'h0001;
            end
        end
    end

    // [RULE10] budget overrun flag
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            time_limit_flag_q <= 1'b0;
        end else if (go_prog || go_se || go_ce || abort) begin
            time_limit_flag_q <= 1'b0;
        end else if (((state_q == FAS_PROG || state_q == FAS_SUSP_PROG) && pcnt_q == 16'(LIMIT_CYC - 1))
                     || ((state_q == FAS_SE_RUN || state_q == FAS_CE_RUN) && ecnt_q == 16'(LIMIT_CYC - 1))) begin
            time_limit_flag_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sect_mask_q <= '0;
        end else if (done_erase || abort) begin
            sect_mask_q <= '0;
        end else if (go_se || add_sect) begin
            sect_mask_q[sect] <= 1'b1;
        end
    end

    // Cells only clear on program, so a locked write leaves the array untouched.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= 16'hFFFF;
            end
        end else if (done_prog) begin
            mem_q[pa_q] <= mem_q[pa_q] & last_program_data_q;
        end else if (done_erase) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (state_q == FAS_CE_RUN || sect_mask_q[i / SECT_WORDS]) begin
                    mem_q[i] <= 16'hFFFF;
                end
            end
        end
    end

    // [RULE9] flip per status read
    // [RULE24] toggles advance on reads
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            alternating_busy_flag_q <= 1'b0;
            suspend_alternating_flag_q <= 1'b0;
        end else if (flag_read) begin
            alternating_busy_flag_q <= ~alternating_busy_flag_q;
            suspend_alternating_flag_q <= ~suspend_alternating_flag_q;
        end
    end

    // [RULE1] ready flag tracks algorithm
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 16'h0000;
            ready_q <= 1'b1;
        end else begin
            ready_q <= !busy_d;
            if (bus.rd) begin
                rdata_q <= flag_read ? status : mem_q[idx];
            end
        end
    end

    assign bus.rdata = rdata_q;
    assign bus.ready = ready_q;
    assign flash_ready_flag_o = ready_q;
    assign time_limit_flag_o = time_limit_flag_q;
endmodule : fas_flash_device
`default_nettype wire

// file: hw/fas_flash_host.sv
// Processor-side end: issues command sequences and polls the status word.
`timescale 1ns/1ps
`default_nettype none
module fas_flash_host (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    fas_if.host bus,
    input wire logic req_i,
    input wire fas_pkg::fas_op_t op_i,
    input wire logic [11:0] addr_i,
    input wire logic [15:0] data_i,
    output logic busy_o,
    output logic done_o,
    output logic fail_o,
    output logic [15:0] rdata_o
);
    import fas_pkg::*;

    typedef enum logic [2:0] {H_IDLE, H_CMD, H_RD, H_LAT, H_WAIT, H_ABORT} fas_hstate_t;

    fas_hstate_t st_q;
    fas_op_t op_q;
    logic [2:0] step_q;
    logic [11:0] addr_q;
    logic [15:0] data_q;
    logic discard_q;
    logic [28:0] seq;
    logic seq_last;
    logic running;

    // Returns {last, address, data} for one write of a command sequence.
    function automatic logic [28:0] seq_f(input fas_op_t op, input logic [2:0] step,
                                          input logic [11:0] a, input logic [15:0] d);
        logic [11:0] sa;
        logic [7:0] sd;
        logic last;
        sa = (step == 3'h1 || step == 3'h4) ? ADDR_UNLOCK2 : ADDR_UNLOCK1;
        sd = (step == 3'h1 || step == 3'h4) ? CMD_UNLOCK2 : CMD_UNLOCK1;
        last = 1'b0;
        case (op)
            OP_PROG: begin
                if (step == 3'h2) begin
                    sd = CMD_PROG;
                end
                if (step == 3'h3) begin
                    return {1'b1, a, d};
                end
            end
            OP_CHIP_ERASE, OP_SECTOR_ERASE: begin
                if (step == 3'h2) begin
                    sd = CMD_ERASE;
                end
                if (step == 3'h5) begin
                    last = 1'b1;
                    sd = op == OP_CHIP_ERASE ? CMD_CHIP : CMD_SECTOR;
                    sa = op == OP_CHIP_ERASE ? ADDR_UNLOCK1 : a;
                end
            end
            OP_SUSPEND: return {1'b1, a, 8'h00, CMD_SUSPEND};
            OP_RESET: return {1'b1, a, 8'h00, CMD_RESET};
            default: return {1'b1, a, 8'h00, CMD_SECTOR};
        endcase
        return {last, sa, 8'h00, sd};
    endfunction : seq_f

    assign seq = seq_f(op_q, step_q, addr_q, data_q);
    assign seq_last = seq[28];
    // [RULE21] completion by polling bit
    assign running = op_q == OP_PROG ? bus.rdata[BIT_POLL] != data_q[7] : !bus.rdata[BIT_POLL];

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= H_IDLE;
            op_q <= OP_READ;
            step_q <= 3'h0;
            addr_q <= 12'h000;
            data_q <= 16'h0000;
            discard_q <= 1'b0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            fail_o <= 1'b0;
            rdata_o <= 16'h0000;
            bus.addr <= 12'h000;
            bus.wdata <= 16'h0000;
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
            bus.size <= SZ_HALF;
            bus.asz_wr <= 1'b0;
            bus.asz <= ASZ_RESET;
        end else begin
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
            bus.asz_wr <= 1'b0;
            done_o <= 1'b0;
            // [RULE3] half-word accesses only
            bus.size <= SZ_HALF;
            case (st_q)
                H_IDLE: begin
                    if (req_i) begin
                        op_q <= op_i;
                        addr_q <= addr_i;
                        data_q <= data_i;
                        step_q <= 3'h0;
                        busy_o <= 1'b1;
                        fail_o <= 1'b0;
                        if (op_i == OP_MODE) begin
                            bus.asz_wr <= 1'b1;
                            bus.asz <= data_i[1:0];
                            busy_o <= 1'b0;
                            done_o <= 1'b1;
                        end else begin
                            st_q <= op_i == OP_READ ? H_RD : H_CMD;
                            // [RULE5] drop first status
                            discard_q <= op_i != OP_READ;
                        end
                    end
                end
                H_CMD: begin
                    bus.wr <= 1'b1;
                    bus.addr <= seq[27:16];
                    bus.wdata <= seq[15:0];
                    step_q <= step_q + 3'h1;
                    if (seq_last) begin
                        st_q <= op_q inside {OP_PROG, OP_CHIP_ERASE, OP_SECTOR_ERASE} ? H_RD : H_ABORT;
                    end
                end
                H_RD: begin
                    bus.rd <= 1'b1;
                    bus.addr <= addr_q;
                    st_q <= H_LAT;
                end
                // Read data appear in the cycle after the strobe and hold until the next read, so sampling earlier sees the old word.
                H_LAT: st_q <= H_WAIT;
                H_WAIT: begin
                    if (discard_q) begin
                        discard_q <= 1'b0;
                        st_q <= H_RD;
                    end else if (op_q == OP_READ || !running) begin
                        rdata_o <= bus.rdata;
                        st_q <= H_IDLE;
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                    end else if (bus.rdata[BIT_TLIM]) begin
                        // [RULE12] fail and reset
                        rdata_o <= bus.rdata;
                        fail_o <= 1'b1;
                        op_q <= OP_RESET;
                        st_q <= H_CMD;
                    end else begin
                        st_q <= H_RD;
                    end
                end
                H_ABORT: begin
                    st_q <= H_IDLE;
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end
endmodule : fas_flash_host
`default_nettype wire

// file: shared/fas_if.sv
// Flash port between the processor-side host and the flash device.
`timescale 1ns/1ps
`default_nettype none
interface fas_if;
    logic [11:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [1:0] size;
    logic [15:0] rdata;
    logic ready;
    logic asz_wr;
    logic [1:0] asz;
    modport device(input addr, input wdata, input wr, input rd, input size, input asz_wr, input asz,
                   output rdata, output ready);
    modport host(output addr, output wdata, output wr, output rd, output size, output asz_wr,
                 output asz, input rdata, input ready);
endinterface : fas_if
`default_nettype wire

// file: shared/fas_pkg.sv
// Shared constants and types for the flash algorithm status flag block.
package fas_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;
    localparam int CLK_PERIOD_NS = 20;
    localparam int SE_TIMEOUT_NS = 35000;
    // Least time, so the count rounds up.
    localparam int SE_TIMEOUT_CYC = (SE_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BIT_POLL = 7;
    localparam int BIT_ALT = 6;
    localparam int BIT_TLIM = 5;
    localparam int BIT_ETMR = 3;
    localparam int BIT_ALT2 = 2;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [7:0] CMD_RESET = 8'hF0;
    localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
    localparam logic [7:0] CMD_PROG = 8'hA0;
    localparam logic [7:0] CMD_ERASE = 8'h80;
    localparam logic [7:0] CMD_CHIP = 8'h10;
    localparam logic [7:0] CMD_SECTOR = 8'h30;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [11:0] ADDR_UNLOCK1 = 12'hAA8;
    localparam logic [11:0] ADDR_UNLOCK2 = 12'h554;
    // Bus access size and access_size_field share one encoding.
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [1:0] ASZ_RESET = SZ_WORD;
    typedef enum logic [2:0] {
        FAS_IDLE, FAS_PROG, FAS_SE_WAIT, FAS_SE_RUN, FAS_CE_RUN, FAS_SE_SUSP, FAS_SUSP_PROG
    } fas_state_t;
    typedef enum logic [3:0] {
        OP_READ, OP_PROG, OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_ADD_SECTOR,
        OP_SUSPEND, OP_RESUME, OP_RESET, OP_MODE
    } fas_op_t;
endpackage : fas_pkg

// file: verif/fas_flash_properties.sv
// Concurrent checks on the flash port between the host and device ends.
`timescale 1ns/1ps
`default_nettype none
module fas_flash_props
    import fas_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [11:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [1:0] size,
    input wire logic [15:0] rdata,
    input wire logic ready,
    input wire logic asz_wr,
    input wire logic [1:0] asz
);
    // A margin around the window edge absorbs the read latency.
    localparam int TMR_LO = SE_TIMEOUT_CYC - 4;
    localparam int TMR_HI = SE_TIMEOUT_CYC + 4;
    logic [1:0] mode_q;
    logic stat_q, have_q, alt_q, alt2_q, p55_q, ers_q, se_q;
    logic [11:0] cnt_q;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            {mode_q, stat_q, have_q, alt_q, alt2_q, p55_q, ers_q, se_q, cnt_q} <= {ASZ_RESET, 19'h00000};
        end else begin
            mode_q <= asz_wr ? asz : mode_q;
            stat_q <= rd && !ready && mode_q == SZ_HALF;
            p55_q <= wr && addr == ADDR_UNLOCK2 && wdata[7:0] == CMD_UNLOCK2;
            have_q <= ready ? 1'b0 : (have_q || stat_q);
            alt_q <= stat_q ? rdata[BIT_ALT] : alt_q;
            alt2_q <= stat_q ? rdata[BIT_ALT2] : alt2_q;
            cnt_q <= (cnt_q == 12'hFFF) ? cnt_q : cnt_q + 12'h001;
            if (wr && p55_q && mode_q == SZ_HALF && (wdata[7:0] == CMD_SECTOR || wdata[7:0] == CMD_CHIP)) begin
                ers_q <= 1'b1;
                se_q <= wdata[7:0] == CMD_SECTOR;
                cnt_q <= 12'h000;
            end else if (ready) begin
                ers_q <= 1'b0;
            end
        end
    end
    sequence s_unlock;
        wr && addr == ADDR_UNLOCK1 && wdata[7:0] == CMD_UNLOCK1 ##1 wr && addr == ADDR_UNLOCK2;
    endsequence
    sequence s_prog_cmd;
        s_unlock ##1 wr && wdata[7:0] == CMD_PROG ##1 wr && mode_q == SZ_HALF;
    endsequence
    a_half_reads: assert property (rd |-> size == SZ_HALF && !wr)
        else $error("flag read not half-word or overlaps a write");
    a_undef_zero: assert property (stat_q |-> rdata[15:8] == 8'h00 && !rdata[4] && rdata[1:0] == 2'h0)
        else $error("undefined status bits not zero");
    a_toggle_flips: assert property (stat_q && have_q |-> rdata[BIT_ALT] != alt_q)
        else $error("toggle bit did not alternate");
    a_toggle2_flips: assert property (stat_q && have_q && ers_q |-> rdata[BIT_ALT2] != alt2_q)
        else $error("second toggle did not alternate in erase");
    a_erase_poll_low: assert property (stat_q && ers_q |-> !rdata[BIT_POLL])
        else $error("polling bit high during erase");
    a_timer_window: assert property (stat_q && ers_q && se_q && cnt_q < TMR_LO |-> !rdata[BIT_ETMR])
        else $error("erase timer set inside window");
    a_timer_expired: assert property (stat_q && ers_q && se_q && cnt_q > TMR_HI |-> rdata[BIT_ETMR])
        else $error("erase timer clear after window");
    a_prog_busy: assert property (s_prog_cmd |=> (!ready) [*8])
        else $error("ready high during program");
    a_rom_idle: assert property (mode_q == SZ_WORD && ready |=> ready)
        else $error("algorithm started in read-only mode");
endmodule : fas_flash_props
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench joining the host and device ends over the flash port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module tb_top;
    import fas_pkg::*;
    typedef struct {logic [15:0] val; logic [15:0] mask; logic fail;} fas_note_t;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic req_i = 1'b0;
    fas_op_t op_i = OP_READ;
    logic [11:0] addr_i = 12'h000;
    logic [15:0] data_i = 16'h0000;
    logic busy_o, done_o, fail_o;
    logic [15:0] rdata_o;
    int num_errors = 0;
    int checks_done = 0;
    fas_note_t notes[$];
    fas_note_t nt;
    logic [15:0] d[4];
    fas_if bus ();
    fas_flash_device #(.LIMIT_CYC(300)) fas_flash_device_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus(bus),
        .flash_ready_flag_o(), .time_limit_flag_o());
    fas_flash_host fas_flash_host_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus(bus), .req_i(req_i), .op_i(op_i),
        .addr_i(addr_i), .data_i(data_i), .busy_o(busy_o), .done_o(done_o), .fail_o(fail_o), .rdata_o(rdata_o));
    fas_flash_props fas_flash_props_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr(bus.addr), .wdata(bus.wdata),
        .wr(bus.wr), .rd(bus.rd), .size(bus.size), .rdata(bus.rdata), .ready(bus.ready), .asz_wr(bus.asz_wr),
        .asz(bus.asz));
    always #10 sys_clk_i = ~sys_clk_i;
    task automatic give_verdict();
        num_errors += notes.size();
        $display("Errors %0d, checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict
    task automatic do_op(input fas_op_t op, input logic [11:0] a, input logic [15:0] dv, input logic [15:0] ev,
                         input logic [15:0] m, input logic ef);
        int n;
        notes.push_back('{ev, m, ef});
        @(posedge sys_clk_i);
        req_i <= 1'b1;
        op_i <= op;
        addr_i <= a;
        data_i <= dv;
        @(posedge sys_clk_i);
        req_i <= 1'b0;
        n = 0;
        while (done_o !== 1'b1 && n < 40000) begin
            @(negedge sys_clk_i);
            n++;
        end
        @(posedge sys_clk_i);
    endtask : do_op
    // The expectation is noted before the request, so a missing result leaves a note behind.
    always @(posedge sys_clk_i) begin
        if (done_o === 1'b1) begin
            nt = notes.pop_front();
            `CHK(rdata_o & nt.mask, nt.val & nt.mask)
            `CHK(fail_o, nt.fail)
        end
    end
    initial begin
        repeat (60000) @(posedge sys_clk_i);
        num_errors++;
        give_verdict();
    end
    initial begin
        void'($urandom(99610));
        repeat (5) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        do_op(OP_PROG, 12'h002, 16'h12B4, 16'hFFFF, 16'hFFFF, 1'b0);
        do_op(OP_READ, 12'h002, 16'h0000, 16'hFFFF, 16'hFFFF, 1'b0);
        do_op(OP_MODE, 12'h000, {14'h0000, SZ_HALF}, 16'h0000, 16'h0000, 1'b0);
        for (int i = 0; i < 4; i++) begin
            d[i] = 16'($urandom()) & 16'h7FFE;
            do_op(OP_PROG, 12'(i * 32), d[i], d[i], 16'hFFFF, 1'b0);
        end
        for (int i = 0; i < 4; i++) begin
            do_op(OP_READ, 12'(i * 32), 16'h0000, d[i], 16'hFFFF, 1'b0);
        end
        // Writing ones over cleared bits never completes, so only the time limit ends it.
        do_op(OP_PROG, 12'h000, 16'hFFFF, 16'h0020, 16'hFFBF, 1'b1);
        do_op(OP_SECTOR_ERASE, 12'h020, 16'h0000, 16'hFFFF, 16'hFFFF, 1'b0);
        do_op(OP_READ, 12'h020, 16'h0000, 16'hFFFF, 16'hFFFF, 1'b0);
        do_op(OP_READ, 12'h040, 16'h0000, d[2], 16'hFFFF, 1'b0);
        do_op(OP_CHIP_ERASE, 12'h000, 16'h0000, 16'hFFFF, 16'hFFFF, 1'b0);
        do_op(OP_READ, 12'h040, 16'h0000, 16'hFFFF, 16'hFFFF, 1'b0);
        @(posedge sys_clk_i);
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
